// file: rtl/tmr_cmp_pkg.sv
// Constants for the compare-toggle timer channel.
// Assumes one core clock; all control fields arrive as plain ports.
package tmr_cmp_pkg;
   localparam logic [2:0] PSC_DIV1 = 3'h0;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [2:0] CLR_ON_A = 3'h1;
   localparam logic [3:0] IOA_TOGGLE_INIT0 = 4'h3;
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMP_A_RST = 16'hFFFF;
   localparam logic STOP_RST = 1'b1;
   localparam logic PIN_RST = 1'b0;
endpackage : tmr_cmp_pkg

// file: rtl/timer_compare_toggle_output.sv
// Timer channel four in output compare toggle mode.
// Assumes register writes arrive as one-cycle strobes synchronous to clk.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Operation
// - Reset puts the unit in module stop; it holds until software cancels.
// - Protected register and counter writes act only while access enable is 1.
// - Counter halts while start bit is 0; counts once it is 1.
// - While stopped the counter can be written; writing zero holds zero.
// - Both prescaler fields 000b select the undivided peripheral clock.
// - Edge select 00b counts on rising edges of the count clock.
// - Clear source 001b clears the counter on compare match with register A.
// - I/O field 0011b: A compares, pin starts 0 and toggles each match.
// - Mode 0000b with buffer bit 0 gives normal unbuffered operation.
// - Once started, the waveform runs in hardware with no software help.
module timer_compare_toggle_output
   import tmr_cmp_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_module_stop_wr,
   input wire logic i_module_stop_val,
   input wire logic i_protected_access_enable,
   input wire logic i_channel_start_bit,
   input wire logic i_channel_counter_wr,
   input wire logic [CNT_W-1:0] i_channel_counter_val,
   input wire logic i_compare_a_wr,
   input wire logic [CNT_W-1:0] i_compare_a_val,
   input wire logic i_ctrl_wr,
   input wire logic [2:0] i_prescaler_select,
   input wire logic [2:0] i_prescaler_select_ext,
   input wire logic [1:0] i_count_edge_select,
   input wire logic [2:0] i_counter_clear_source,
   input wire logic [3:0] i_output_a_io_control,
   input wire logic [3:0] i_operating_mode_field,
   input wire logic i_buffer_op_a,
   input wire logic i_output_a_pin_enable,
   output logic o_compare_output_pin,
   output logic o_compare_output_pin_oe,
   output logic [CNT_W-1:0] o_channel_counter,
   output logic o_module_stopped
);
   logic stop_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] cmp_a_ff;
   logic [2:0] psc_ff;
   logic [2:0] psc2_ff;
   logic [1:0] edge_ff;
   logic [2:0] clr_ff;
   logic [3:0] ioa_ff;
   logic [3:0] mode_ff;
   logic bfa_ff;
   logic pin_ff;
   logic oe_ff;
   logic pin_out_ff;
   logic prot_wr_ok;
   logic running;
   logic cnt_tick;
   logic match_a;
   logic [CNT_W-1:0] nxt_cnt;

   ////////////////////////////////////////////////////////////////////////
   // Only the undivided rising-edge setting counts; others are not built
   assign prot_wr_ok = i_protected_access_enable && !stop_ff;
   assign running = i_channel_start_bit && !stop_ff;
   assign cnt_tick = running && psc_ff == PSC_DIV1
      && psc2_ff == PSC_DIV1 && edge_ff == EDGE_RISE;
   assign match_a = cnt_tick && cnt_ff == cmp_a_ff
      && mode_ff == MODE_NORMAL && !bfa_ff;

   always_comb begin
      nxt_cnt = cnt_ff + 1'b1;
      if (match_a && clr_ff == CLR_ON_A) begin
         nxt_cnt = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Module stop: the stopped unit ignores all writes except to module stop, as its clock is withheld
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stop_ff <= STOP_RST;
      end else if (i_module_stop_wr) begin
         stop_ff <= i_module_stop_val;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         psc_ff <= 3'h0;
         psc2_ff <= 3'h0;
         edge_ff <= 2'h0;
         clr_ff <= 3'h0;
         ioa_ff <= 4'h0;
         mode_ff <= 4'h0;
         bfa_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else if (i_ctrl_wr && prot_wr_ok) begin
         psc_ff <= i_prescaler_select;
         psc2_ff <= i_prescaler_select_ext;
         edge_ff <= i_count_edge_select;
         clr_ff <= i_counter_clear_source;
         ioa_ff <= i_output_a_io_control;
         mode_ff <= i_operating_mode_field;
         bfa_ff <= i_buffer_op_a;
         oe_ff <= i_output_a_pin_enable;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cmp_a_ff <= CMP_A_RST;
      end else if (i_compare_a_wr && prot_wr_ok) begin
         cmp_a_ff <= i_compare_a_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter: direct writes only while halted, so no write/count race
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_ff <= CNT_RST;
      end else if (i_channel_counter_wr && prot_wr_ok && !running) begin
         cnt_ff <= i_channel_counter_val;
      end else if (cnt_tick) begin
         cnt_ff <= nxt_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Toggle output; the pin level resets to 0 whenever the mode is written
   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_ff <= PIN_RST;
      end else if (i_ctrl_wr && prot_wr_ok) begin
         pin_ff <= PIN_RST;
      end else if (match_a && ioa_ff == IOA_TOGGLE_INIT0) begin
         pin_ff <= !pin_ff;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_out_ff <= 1'b0;
         o_compare_output_pin_oe <= 1'b0;
         o_channel_counter <= CNT_RST;
         o_module_stopped <= STOP_RST;
      end else begin
         pin_out_ff <= oe_ff && pin_ff;
         o_compare_output_pin_oe <= oe_ff && !stop_ff;
         o_channel_counter <= cnt_ff;
         o_module_stopped <= stop_ff;
      end
   end
   assign o_compare_output_pin = pin_out_ff;

   ////////////////////////////////////////////////////////////////////////
   a_stop_reset: assert property (@(posedge i_core_clk)
      $fell(i_sys_rst) |-> stop_ff)
      else $error("unit not stopped after reset");
   a_prot_block: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_compare_a_wr && !i_protected_access_enable) |=>
      $stable(cmp_a_ff))
      else $error("protected write took effect");
   a_halt_hold: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (!i_channel_start_bit && !i_channel_counter_wr) |=>
      $stable(cnt_ff))
      else $error("counter moved while halted");
   a_write_zero: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_channel_counter_wr && prot_wr_ok && !running
      && i_channel_counter_val == '0) |=> cnt_ff == '0)
      else $error("counter write lost");
   a_count_step: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (cnt_tick && !match_a) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not step");
   a_clear_match: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (match_a && clr_ff == CLR_ON_A) |=> cnt_ff == '0)
      else $error("counter not cleared on match");
   a_pin_toggle: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (match_a && ioa_ff == IOA_TOGGLE_INIT0 && !i_ctrl_wr)
      |=> pin_ff != $past(pin_ff))
      else $error("pin did not toggle");
   a_pin_gate: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      !oe_ff |=> !o_compare_output_pin && !o_compare_output_pin_oe)
      else $error("pin driven while disabled");

   ////////////////////////////////////////////////////////////////////////
   // Extra guards on the edges of the behaviour: wrap, parked counter,
   // pin start level and the stopped unit never driving its pin
   a_wrap_zero: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (cnt_tick && cnt_ff == '1 && !(match_a && clr_ff == CLR_ON_A))
      |=> cnt_ff == '0)
      else $error("counter did not wrap to zero");

   // Unsupported clock settings leave the counter parked, never wrong
   a_unsup_hold: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (!cnt_tick && !i_channel_counter_wr) |=> $stable(cnt_ff))
      else $error("counter moved without a count tick");

   a_pin_init: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      (i_ctrl_wr && prot_wr_ok) |=> !pin_ff)
      else $error("pin level not cleared on setup");

   // A stopped unit has no clock, so its pin must be released
   a_stop_release: assert property (@(posedge i_core_clk)
      disable iff (i_sys_rst)
      stop_ff |=> !o_compare_output_pin_oe)
      else $error("pin driven while module stopped");
endmodule : timer_compare_toggle_output

// file: tb/pulse_sink.sv
// Load on the compare output pin; measures each half period in cycles.
// Assumes the pin toggles in the core clock domain.
`timescale 1ns/100ps
module pulse_sink (
   input wire logic i_core_clk,
   input wire logic i_pin,
   input wire logic i_pin_oe,
   output logic [15:0] o_half_ff
);
   // Pull-down on the board holds the line low when the pin is released
   wire line = i_pin_oe ? i_pin : 1'b0;
   logic last_ff = 1'b0;
   logic [15:0] cnt_ff = 16'h0000;
   initial o_half_ff = 16'h0000;
   // Plain always: the start values above are a second writer
   always @(posedge i_core_clk) begin
      last_ff <= line;
      cnt_ff <= (line != last_ff) ? 16'h0000 : cnt_ff + 16'h0001;
      if (line != last_ff) o_half_ff <= cnt_ff + 16'h0001;
   end
endmodule : pulse_sink

// file: tb/timer_compare_toggle_output_tb.sv
// Self-checking bench for the compare-toggle timer channel.
// Assumes registered outputs one edge behind the internal state.
`timescale 1ns/100ps
module timer_compare_toggle_output_tb;
   import tmr_cmp_pkg::*;
   logic clk = 0, rst = 1, stop_wr = 0, stop_val = 1, acc = 0, start = 0;
   logic cnt_wr = 0, cmp_wr = 0, ctrl_wr = 0, oe_en = 0;
   logic [15:0] cnt_val = 16'h0000, cmp_val = 16'h0000, cnt, half, prev;
   logic [3:0] output_a_io_control = 4'h0;
   logic [2:0] clr = 3'h0;
   logic pin, pin_oe, stopped;
   int n_mismatch = 0, num_checks = 0;
   ////////////////////////////////////////
   timer_compare_toggle_output uut (.i_core_clk(clk), .i_sys_rst(rst),
      .i_module_stop_wr(stop_wr), .i_module_stop_val(stop_val),
      .i_protected_access_enable(acc), .i_channel_start_bit(start),
      .i_channel_counter_wr(cnt_wr), .i_channel_counter_val(cnt_val),
      .i_compare_a_wr(cmp_wr), .i_compare_a_val(cmp_val),
      .i_ctrl_wr(ctrl_wr), .i_prescaler_select(PSC_DIV1),
      .i_prescaler_select_ext(PSC_DIV1), .i_count_edge_select(EDGE_RISE),
      .i_counter_clear_source(clr), .i_output_a_io_control(output_a_io_control),
      .i_operating_mode_field(MODE_NORMAL), .i_buffer_op_a(1'b0),
      .i_output_a_pin_enable(oe_en), .o_compare_output_pin(pin),
      .o_compare_output_pin_oe(pin_oe), .o_channel_counter(cnt),
      .o_module_stopped(stopped));
   pulse_sink load (.i_core_clk(clk), .i_pin(pin), .i_pin_oe(pin_oe),
      .o_half_ff(half));
   ////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One-cycle strobe: 0 stop, 1 counter, 2 compare, 3 control
   task automatic strobe(input int k);
      @(negedge clk);
      {stop_wr, cnt_wr, cmp_wr, ctrl_wr} = 4'h8 >> k;
      @(negedge clk);
      {stop_wr, cnt_wr, cmp_wr, ctrl_wr} = 4'h0;
      @(negedge clk);
   endtask : strobe
   task automatic t_reset();
      chk("stopped", 16'h0001, {15'h0, stopped});
      chk("pin_oe", 16'h0000, {15'h0, pin_oe});
      acc = 1;
      cnt_val = 16'h1234;
      strobe(1);
      chk("cnt while stopped", 16'h0000, cnt);
      $display("test reset done");
   endtask : t_reset
   task automatic t_protect();
      stop_val = 0;
      strobe(0);
      chk("stopped", 16'h0000, {15'h0, stopped});
      acc = 0;
      cnt_val = 16'h0055;
      strobe(1);
      chk("cnt protected", 16'h0000, cnt);
      acc = 1;
      strobe(1);
      chk("cnt written", 16'h0055, cnt);
      cnt_val = 16'h0000;
      strobe(1);
      chk("cnt zeroed", 16'h0000, cnt);
      $display("test protect done");
   endtask : t_protect
   task automatic t_wrap();
      cnt_val = 16'hFFFC;
      strobe(3);
      strobe(1);
      start = 1;
      repeat (2) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         prev = cnt;
         @(negedge clk);
         chk("cnt step", prev + 16'h0001, cnt);
      end
      start = 0;
      repeat (2) @(negedge clk);
      prev = cnt;
      repeat (3) @(negedge clk);
      chk("cnt halted", prev, cnt);
      $display("test wrap done");
   endtask : t_wrap
   task automatic t_toggle();
      clr = CLR_ON_A;
      output_a_io_control = IOA_TOGGLE_INIT0;
      oe_en = 1;
      strobe(3);
      chk("pin init", 16'h0002, {14'h0, pin_oe, pin});
      cnt_val = 16'h0000;
      strobe(1);
      cmp_val = 16'h0009;
      strobe(2);
      acc = 0;
      start = 1;
      repeat (60) @(negedge clk);
      chk("half period", 16'h000A, half);
      cmp_val = 16'h0003;
      strobe(2);
      repeat (40) @(negedge clk);
      chk("half kept", 16'h000A, half);
      acc = 1;
      oe_en = 0;
      strobe(3);
      chk("pin off", 16'h0000, {14'h0, pin_oe, pin});
      $display("test toggle done");
   endtask : t_toggle
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////
   initial forever #2.5 clk = ~clk;
   // Whole run is about 160 cycles; the 5000-cycle limit, some thirty times that, means a hang
   initial begin
      #(5000 * 5);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 0;
      @(negedge clk);
      t_reset();
      t_protect();
      t_wrap();
      t_toggle();
      tally_and_finish();
   end
endmodule : timer_compare_toggle_output_tb
